/* src/ddr2_cmd_pkg.sv */
// Summary of operation
// - Reads and writes run as bursts of four or eight words in programmed order.
// - Activate takes bank from bank inputs, row from address 0-13 (x16) or 0-14 (x8).
// - Column commands take start column from address 0-9; address 10 asks auto precharge.
// - All command and address inputs are captured on the rising clock edge.
// - Read data is timed to both crossings of the clock pair.
// - Clock enable low: precharge power-down or self refresh if idle, else active power-down.
// - Clock enable is synchronous except for self-refresh exit, where it is asynchronous.
// - Power-down disables all receivers except clocks, termination control and clock enable.
// - Self refresh disables all receivers except clock enable.
// - Commands registered with chip select high are ignored.
// - Chip select is decoded with row strobe, column strobe and write enable.
// - Read column latency is programmable from three to seven cycles.
// - Additive latency of zero to six cycles is added to column latency.
// - Write latency is read latency minus one; controller presents write data then.
// - Eight banks each hold their own open row at the same time.
// - Two data words move per clock, four-word prefetch per column access.
// - Output drive strength selectable between full and reduced.
// - An internal delay-locked loop aligns data outputs with the clock.
// - Precharge with address 10 low closes the named bank, high closes all.
// - Mode register commands pick the register by bank inputs, opcode on address.
// - A write byte with its mask bit sampled high is discarded.
package ddr2_cmd_pkg;

	// ==========================================
	// Widths
	localparam int BANK_W = 3;
	localparam int NBANK = 8;
	localparam int ADDR_W = 15;
	localparam int COL_W = 10;
	localparam int DQ_W = 16;
	localparam int DM_W = 2;
	localparam int MEM_COL_W = 4;
	localparam int MEM_DEPTH = 128;
	localparam int PIPE_D = 16;
	localparam int LAT_W = 4;

	// ==========================================
	// Command codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;

	// ==========================================
	// Address fields and mode register layout
	localparam int AP_BIT = 10;
	localparam int ROW_X16_W = 14;
	localparam logic [BANK_W-1:0] BA_MR = 3'h0;
	localparam logic [BANK_W-1:0] BA_EMR1 = 3'h1;
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int EMR_DLL_BIT = 0;
	localparam int EMR_DS_BIT = 1;
	localparam int EMR_AL_LSB = 3;
	localparam logic [2:0] BL8_CODE = 3'h3;
	localparam logic [2:0] CL_MIN = 3'h3;
	localparam logic [2:0] AL_MAX = 3'h6;
	localparam logic [ADDR_W-1:0] MR_RESET = 15'h0032;
	localparam logic [ADDR_W-1:0] EMR_RESET = 15'h0000;
	localparam logic [1:0] PAIR_LAST_BL4 = 2'h1;
	localparam logic [1:0] PAIR_LAST_BL8 = 2'h3;
	localparam logic [7:0] DLL_LOCK_CYC = 8'hC8;

	// ==========================================
	// Power states
	typedef enum logic [1:0] {ST_ACTIVE, ST_PPD, ST_APD, ST_SREF} power_state_t;

endpackage

/* src/ddr2_sdram_command_interface.sv */
`timescale 1ns/100ps
module ddr2_sdram_command_interface
	import ddr2_cmd_pkg::*;
(
	// System clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// Link clock and command pins
	input wire logic ck_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic odt_i,
	input wire logic [BANK_W-1:0] ba_i,
	input wire logic [ADDR_W-1:0] a_i,
	// Width strap
	input wire logic width_x8_i,
	// Data pins, rising and falling word
	input wire logic [DQ_W-1:0] dq_hi_i,
	input wire logic [DQ_W-1:0] dq_lo_i,
	input wire logic [DM_W-1:0] dm_hi_i,
	input wire logic [DM_W-1:0] dm_lo_i,
	output logic [DQ_W-1:0] dq_hi_o,
	output logic [DQ_W-1:0] dq_lo_o,
	output logic dq_oe_n_o,
	// Pin side controls
	output logic drive_half_o,
	output logic dll_locked_o,
	output logic rx_cmd_en_o,
	output logic rx_clk_en_o,
	output logic odt_en_o,
	// Status on system clock
	output logic pd_o,
	output logic sref_o,
	output logic [NBANK-1:0] banks_open_o
);

	// ==========================================
	// Helpers
	// Column of one word within the burst
	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
		input logic [2:0] idx, input logic bl8, input logic intlv);
		logic [2:0] m;
		logic [2:0] off;
		m = bl8 ? 3'h7 : 3'h3;
		off = intlv ? (start[2:0] ^ idx) : 3'(start[2:0] + idx);
		burst_col = {start[COL_W-1:3], (start[2:0] & ~m) | (off & m)};
	endfunction

	// Storage index of a bank and column
	function automatic logic [6:0] mem_idx(input logic [BANK_W-1:0] b,
		input logic [COL_W-1:0] c);
		mem_idx = {b, c[MEM_COL_W-1:0]};
	endfunction

	// ==========================================
	// Link domain state
	power_state_t pwr_reg, pwr_next;
	logic [NBANK-1:0] open_reg, open_next;
	logic [ADDR_W-1:0] row_reg [NBANK], row_next [NBANK];
	logic [ADDR_W-1:0] mr_reg, mr_next, emr_reg, emr_next;
	logic [PIPE_D-1:0] pv_reg, pv_next, prd_reg, prd_next, pap_reg, pap_next;
	logic [BANK_W-1:0] pba_reg [PIPE_D], pba_next [PIPE_D];
	logic [COL_W-1:0] pcol_reg [PIPE_D], pcol_next [PIPE_D];
	logic act_reg, act_next, rd_reg, rd_next, ap_reg, ap_next;
	logic [BANK_W-1:0] ba_reg, ba_next;
	logic [COL_W-1:0] col_reg, col_next;
	logic [1:0] pair_reg, pair_next;
	logic [DQ_W-1:0] dqh_reg, dqh_next, dql_reg, dql_next;
	logic oe_n_reg, oe_n_next;
	logic [7:0] lock_cnt_reg, lock_cnt_next;
	logic ds_reg, ds_next, lock_reg, lock_next;
	logic rxc_reg, rxc_next, rxk_reg, rxk_next, odt_reg, odt_next;
	logic pd_flag_reg, pd_flag_next, sref_flag_reg, sref_flag_next;
	logic sref_armed_reg, sref_armed_next;
	logic x8_s1_reg, x8_s2_reg, cke_s1_reg, cke_s2_reg;
	logic [DQ_W-1:0] mem [MEM_DEPTH];

	// Write ports into storage
	logic we_h, we_l;
	logic [6:0] wi_h, wi_l;
	logic [DQ_W-1:0] wd_h, wd_l;

	// Decode and latency
	logic [3:0] cmd;
	logic cmd_ok;
	logic [2:0] cl, al;
	logic [LAT_W-1:0] lat;
	logic bl8, intlv;
	logic cur_v, cur_rd, cur_ap, last;
	logic [BANK_W-1:0] cur_ba;
	logic [COL_W-1:0] cur_col;
	logic [1:0] cur_pair;

	// ==========================================
	// Pin synchronisers on the link clock
	// asynchronous self-refresh exit
	always_ff @(posedge ck_i or negedge nrst_i) begin
		if (!nrst_i) begin
			x8_s1_reg <= 1'b0;
			x8_s2_reg <= 1'b0;
			cke_s1_reg <= 1'b0;
			cke_s2_reg <= 1'b0;
		end else begin
			x8_s1_reg <= width_x8_i;
			x8_s2_reg <= x8_s1_reg;
			cke_s1_reg <= cke_i;
			cke_s2_reg <= cke_s1_reg;
		end
	end

	// ==========================================
	// Next state of the link logic
	always_comb begin
		// chip select is part of the code
		cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
		// deselected commands and disabled receivers ignored
		cmd_ok = (pwr_reg == ST_ACTIVE) && cke_i && !cs_n_i;
		bl8 = (mr_reg[MR_BL_LSB +: 3] == BL8_CODE);
		intlv = mr_reg[MR_BT_BIT];
		cl = (mr_reg[MR_CL_LSB +: 3] < CL_MIN) ? CL_MIN : mr_reg[MR_CL_LSB +: 3];
		al = (emr_reg[EMR_AL_LSB +: 3] > AL_MAX) ? AL_MAX : emr_reg[EMR_AL_LSB +: 3];
		lat = LAT_W'({1'b0, cl} + {1'b0, al});
		pwr_next = pwr_reg;
		open_next = open_reg;
		row_next = row_reg;
		mr_next = mr_reg;
		emr_next = emr_reg;
		// Latency pipeline shifts toward slot zero
		for (int i = 0; i < PIPE_D - 1; i++) begin
			pv_next[i] = pv_reg[i+1];
			prd_next[i] = prd_reg[i+1];
			pap_next[i] = pap_reg[i+1];
			pba_next[i] = pba_reg[i+1];
			pcol_next[i] = pcol_reg[i+1];
		end
		pv_next[PIPE_D-1] = 1'b0;
		prd_next[PIPE_D-1] = 1'b0;
		pap_next[PIPE_D-1] = 1'b0;
		pba_next[PIPE_D-1] = '0;
		pcol_next[PIPE_D-1] = '0;

		// Burst engine: a new burst takes over a running one
		if (pv_reg[0]) begin
			cur_v = 1'b1;
			cur_rd = prd_reg[0];
			cur_ap = pap_reg[0];
			cur_ba = pba_reg[0];
			cur_col = pcol_reg[0];
			cur_pair = 2'h0;
		end else begin
			cur_v = act_reg;
			cur_rd = rd_reg;
			cur_ap = ap_reg;
			cur_ba = ba_reg;
			cur_col = col_reg;
			cur_pair = pair_reg;
		end
		// burst of four or eight words
		last = cur_pair == (bl8 ? PAIR_LAST_BL8 : PAIR_LAST_BL4);
		act_next = cur_v && !last;
		rd_next = cur_rd;
		ap_next = cur_ap;
		ba_next = cur_ba;
		col_next = cur_col;
		pair_next = 2'(cur_pair + 2'h1);
		wi_h = mem_idx(cur_ba, burst_col(cur_col, {cur_pair, 1'b0}, bl8, intlv));
		wi_l = mem_idx(cur_ba, burst_col(cur_col, {cur_pair, 1'b1}, bl8, intlv));
		// two words per clock from one prefetch
		// word pair for both clock crossings
		oe_n_next = !(cur_v && cur_rd);
		dqh_next = (cur_v && cur_rd) ? mem[wi_h] : '0;
		dql_next = (cur_v && cur_rd) ? mem[wi_l] : '0;
		// write data sampled one cycle ahead of read timing
		we_h = cur_v && !cur_rd;
		we_l = cur_v && !cur_rd;
		for (int b = 0; b < DM_W; b++) begin
			wd_h[b*8 +: 8] = dm_hi_i[b] ? mem[wi_h][b*8 +: 8] : dq_hi_i[b*8 +: 8];
			wd_l[b*8 +: 8] = dm_lo_i[b] ? mem[wi_l][b*8 +: 8] : dq_lo_i[b*8 +: 8];
		end
		if (cur_v && last && cur_ap) begin
			open_next[cur_ba] = 1'b0;
		end

		// Command decode
		if (cmd_ok) begin
			unique case (cmd)
				CMD_ACT: begin
					open_next[ba_i] = 1'b1;
					row_next[ba_i] = x8_s2_reg ? a_i : {1'b0, a_i[ROW_X16_W-1:0]};
				end
				CMD_PRE: begin
					if (a_i[AP_BIT]) begin
						open_next = '0;
					end else begin
						open_next[ba_i] = 1'b0;
					end
				end
				CMD_MRS: begin
					if (ba_i == BA_MR) begin
						mr_next = a_i;
					end else if (ba_i == BA_EMR1) begin
						emr_next = a_i;
					end
				end
				CMD_RD, CMD_WR: begin
					if (open_reg[ba_i]) begin
						pv_next[lat-1] = 1'b1;
						prd_next[lat-1] = (cmd == CMD_RD);
						pap_next[lat-1] = a_i[AP_BIT];
						pba_next[lat-1] = ba_i;
						pcol_next[lat-1] = a_i[COL_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// power state entry by open banks
		unique case (pwr_reg)
			ST_ACTIVE: begin
				if (!cke_i) begin
					if (!cs_n_i && cmd == CMD_REF && open_reg == '0) begin
						pwr_next = ST_SREF;
					end else if (open_reg == '0) begin
						pwr_next = ST_PPD;
					end else begin
						pwr_next = ST_APD;
					end
				end
			end
			ST_PPD, ST_APD: begin
				if (cke_i) begin
					pwr_next = ST_ACTIVE;
				end
			end
			// Stale high enable in the synchroniser must not end self refresh
			ST_SREF: begin
				if (cke_s2_reg && sref_armed_reg) begin
					pwr_next = ST_ACTIVE;
				end
			end
		endcase
		// Armed once the synchronised enable is seen low in self refresh
		sref_armed_next = (pwr_next == ST_SREF) && (sref_armed_reg || !cke_s2_reg);
		rxc_next = (pwr_next == ST_ACTIVE);
		rxk_next = (pwr_next != ST_SREF);
		odt_next = (pwr_next != ST_SREF) && odt_i;
		pd_flag_next = (pwr_next == ST_PPD) || (pwr_next == ST_APD);
		sref_flag_next = (pwr_next == ST_SREF);
		ds_next = emr_next[EMR_DS_BIT];
		if (emr_reg[EMR_DLL_BIT] || pwr_reg == ST_SREF) begin
			lock_cnt_next = '0;
		end else if (lock_cnt_reg != DLL_LOCK_CYC) begin
			lock_cnt_next = 8'(lock_cnt_reg + 8'h01);
		end else begin
			lock_cnt_next = lock_cnt_reg;
		end
		lock_next = (lock_cnt_next == DLL_LOCK_CYC);
	end

	// ==========================================
	// Link registers
	// inputs captured on rising clock
	always_ff @(posedge ck_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pwr_reg <= ST_ACTIVE;
			open_reg <= '0;
			for (int i = 0; i < NBANK; i++) begin
				row_reg[i] <= '0;
			end
			mr_reg <= MR_RESET;
			emr_reg <= EMR_RESET;
			pv_reg <= '0;
			prd_reg <= '0;
			pap_reg <= '0;
			for (int i = 0; i < PIPE_D; i++) begin
				pba_reg[i] <= '0;
				pcol_reg[i] <= '0;
			end
			act_reg <= 1'b0;
			rd_reg <= 1'b0;
			ap_reg <= 1'b0;
			ba_reg <= '0;
			col_reg <= '0;
			pair_reg <= '0;
			dqh_reg <= '0;
			dql_reg <= '0;
			oe_n_reg <= 1'b1;
			lock_cnt_reg <= '0;
			lock_reg <= 1'b0;
			ds_reg <= 1'b0;
			rxc_reg <= 1'b1;
			rxk_reg <= 1'b1;
			odt_reg <= 1'b0;
			pd_flag_reg <= 1'b0;
			sref_flag_reg <= 1'b0;
			sref_armed_reg <= 1'b0;
		end else begin
			pwr_reg <= pwr_next;
			open_reg <= open_next;
			row_reg <= row_next;
			mr_reg <= mr_next;
			emr_reg <= emr_next;
			pv_reg <= pv_next;
			prd_reg <= prd_next;
			pap_reg <= pap_next;
			pba_reg <= pba_next;
			pcol_reg <= pcol_next;
			act_reg <= act_next;
			rd_reg <= rd_next;
			ap_reg <= ap_next;
			ba_reg <= ba_next;
			col_reg <= col_next;
			pair_reg <= pair_next;
			dqh_reg <= dqh_next;
			dql_reg <= dql_next;
			oe_n_reg <= oe_n_next;
			lock_cnt_reg <= lock_cnt_next;
			lock_reg <= lock_next;
			ds_reg <= ds_next;
			rxc_reg <= rxc_next;
			rxk_reg <= rxk_next;
			odt_reg <= odt_next;
			pd_flag_reg <= pd_flag_next;
			sref_flag_reg <= sref_flag_next;
			sref_armed_reg <= sref_armed_next;
		end
	end

	// Storage array, no reset
	always_ff @(posedge ck_i) begin
		if (we_h) begin
			mem[wi_h] <= wd_h;
		end
		if (we_l) begin
			mem[wi_l] <= wd_l;
		end
	end

	assign dq_hi_o = dqh_reg;
	assign dq_lo_o = dql_reg;
	assign dq_oe_n_o = oe_n_reg;
	assign drive_half_o = ds_reg;
	assign dll_locked_o = lock_reg;
	assign rx_cmd_en_o = rxc_reg;
	assign rx_clk_en_o = rxk_reg;
	assign odt_en_o = odt_reg;

	// ==========================================
	// Status crossing into the system clock
	logic pd_s1_reg, pd_s2_reg, sref_s1_reg, sref_s2_reg;
	logic [NBANK-1:0] open_s1_reg, open_s2_reg;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pd_s1_reg <= 1'b0;
			pd_s2_reg <= 1'b0;
			sref_s1_reg <= 1'b0;
			sref_s2_reg <= 1'b0;
			open_s1_reg <= '0;
			open_s2_reg <= '0;
		end else begin
			pd_s1_reg <= pd_flag_reg;
			pd_s2_reg <= pd_s1_reg;
			sref_s1_reg <= sref_flag_reg;
			sref_s2_reg <= sref_s1_reg;
			open_s1_reg <= open_reg;
			open_s2_reg <= open_s1_reg;
		end
	end

	assign pd_o = pd_s2_reg;
	assign sref_o = sref_s2_reg;
	assign banks_open_o = open_s2_reg;

endmodule

/* testbench/ddr2_cmd_checker.sv */
`timescale 1ns/100ps
// ==========================================
// Port checker for the command interface
module ddr2_cmd_checker
	import ddr2_cmd_pkg::*;
(
	// Clocks and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic ck_i,
	// Command pins
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	// Watched outputs
	input wire logic [DQ_W-1:0] dq_hi_o,
	input wire logic [DQ_W-1:0] dq_lo_o,
	input wire logic dq_oe_n_o,
	input wire logic dll_locked_o,
	input wire logic rx_cmd_en_o,
	input wire logic rx_clk_en_o,
	input wire logic pd_o,
	input wire logic sref_o
);
	logic [3:0] rd_age_reg;
	logic [3:0] rd_age_next;
	logic rd_seen;

	// Edges since the last selected read, saturating
	assign rd_seen = cke_i && ({cs_n_i, ras_n_i, cas_n_i, we_n_i} == CMD_RD);
	always_comb begin
		rd_age_next = rd_age_reg;
		if (rd_seen) begin
			rd_age_next = 4'h0;
		end else if (rd_age_reg != 4'hF) begin
			rd_age_next = rd_age_reg + 4'h1;
		end
	end
	always_ff @(posedge ck_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_age_reg <= 4'hF;
		end else begin
			rd_age_reg <= rd_age_next;
		end
	end

	// Burst and wake-up steps
	sequence s_burst_open;
		!dq_oe_n_o [*2];
	endsequence
	sequence s_cmd_back;
		##[1:2] rx_cmd_en_o;
	endsequence

	// data only after a selected read
	a_rd_latency: assert property (@(posedge ck_i) disable iff (!nrst_i)
		$fell(dq_oe_n_o) |-> (rd_age_reg >= 4'h3) && (rd_age_reg <= 4'hD))
		else $error("Read data started outside the latency window");
	a_burst_len: assert property (@(posedge ck_i) disable iff (!nrst_i)
		$fell(dq_oe_n_o) |-> s_burst_open)
		else $error("Read burst shorter than two pairs");
	a_data_idle: assert property (@(posedge ck_i) disable iff (!nrst_i)
		dq_oe_n_o |-> (dq_hi_o == 16'h0000) && (dq_lo_o == 16'h0000))
		else $error("Data outputs not quiet while not driving");
	a_pd_entry: assert property (@(posedge ck_i) disable iff (!nrst_i)
		!cke_i && rx_cmd_en_o && rx_clk_en_o |-> ##[1:2] !rx_cmd_en_o)
		else $error("Clock enable low did not leave the active state");
	a_pd_exit: assert property (@(posedge ck_i) disable iff (!nrst_i)
		cke_i && !rx_cmd_en_o && rx_clk_en_o |-> s_cmd_back)
		else $error("Power-down exit too slow");
	a_sref_rx: assert property (@(posedge ck_i) disable iff (!nrst_i)
		!rx_clk_en_o |-> !rx_cmd_en_o)
		else $error("Command receivers on in self refresh");
	a_sref_exit: assert property (@(posedge ck_i) disable iff (!nrst_i)
		cke_i && !rx_clk_en_o |-> ##[1:5] rx_clk_en_o)
		else $error("Self-refresh exit too slow");
	a_dll_drop: assert property (@(posedge ck_i) disable iff (!nrst_i)
		!rx_clk_en_o |-> ##[0:2] !dll_locked_o)
		else $error("Lock flag kept in self refresh");
	// one power state at a time
	a_state_excl: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!(pd_o && sref_o))
		else $error("Power-down and self refresh both flagged");
endmodule

bind ddr2_sdram_command_interface ddr2_cmd_checker i_ddr2_cmd_checker (
	.mclk_i(mclk_i), .nrst_i(nrst_i), .ck_i(ck_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
	.ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .dq_hi_o(dq_hi_o),
	.dq_lo_o(dq_lo_o), .dq_oe_n_o(dq_oe_n_o), .dll_locked_o(dll_locked_o),
	.rx_cmd_en_o(rx_cmd_en_o), .rx_clk_en_o(rx_clk_en_o), .pd_o(pd_o), .sref_o(sref_o)
);

/* testbench/ddr2_host.sv */
`timescale 1ns/100ps
// ==========================================
// Behavioural memory controller on the link
module ddr2_host
	import ddr2_cmd_pkg::*;
(
	// Link clock
	input wire logic ck_i,
	// Command pins
	output logic cke_o,
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic [BANK_W-1:0] ba_o,
	output logic [ADDR_W-1:0] a_o,
	// Write data and masks
	output logic [DQ_W-1:0] dq_hi_o,
	output logic [DQ_W-1:0] dq_lo_o,
	output logic [DM_W-1:0] dm_hi_o,
	output logic [DM_W-1:0] dm_lo_o,
	// Read data
	input wire logic [DQ_W-1:0] dq_hi_i,
	input wire logic [DQ_W-1:0] dq_lo_i,
	input wire logic dq_oe_n_i
);
	logic [DQ_W-1:0] rd_words [16];
	logic rd_oe_n [8];

	// Idle pins at time zero
	initial begin
		cke_o = 1'b1;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
		ba_o = 3'h0;
		a_o = 15'h0000;
		dq_hi_o = 16'h0000;
		dq_lo_o = 16'hFFFF;
		dm_hi_o = 2'h0;
		dm_lo_o = 2'h0;
	end

	// one coded command, then no-op with flipped address
	task automatic send(input logic [3:0] code, input logic [BANK_W-1:0] bank,
		input logic [ADDR_W-1:0] addr, input logic ke);
		@(posedge ck_i);
		#2;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = code;
		ba_o = bank;
		a_o = addr;
		cke_o = ke;
		@(posedge ck_i);
		#2;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
		ba_o = ~bank;
		a_o = ~addr;
	endtask

	task automatic set_cke(input logic ke);
		@(posedge ck_i);
		#2;
		cke_o = ke;
	endtask

	// close all rows, then load both mode registers
	task automatic mode_set(input logic [ADDR_W-1:0] mr, input logic [ADDR_W-1:0] emr);
		send(CMD_PRE, 3'h0, 15'h0400, 1'b1);
		send(CMD_MRS, BA_MR, mr, 1'b1);
		send(CMD_MRS, BA_EMR1, emr, 1'b1);
	endtask

	// pairs at write latency, clock enable kept high
	task automatic wr_burst(input logic [BANK_W-1:0] bank, input int wl, input int pairs,
		input logic [3:0] tag, input logic [DM_W-1:0] dmh);
		send(CMD_WR, bank, 15'h0000, 1'b1);
		repeat (wl) @(posedge ck_i);
		for (int k = 0; k < pairs; k++) begin
			#2;
			dq_hi_o = {tag, 12'(2 * k)};
			dq_lo_o = {tag, 12'(2 * k + 1)};
			dm_hi_o = dmh;
			@(posedge ck_i);
		end
		#2;
		dq_hi_o = ~dq_hi_o;
		dq_lo_o = ~dq_lo_o;
		dm_hi_o = 2'h0;
	endtask

	// read of an open row, pairs captured after each edge
	task automatic rd_burst(input logic [3:0] code, input logic [BANK_W-1:0] bank,
		input logic [ADDR_W-1:0] addr, input int rl, input int pairs);
		send(code, bank, addr, 1'b1);
		repeat (rl) @(posedge ck_i);
		for (int k = 0; k < pairs; k++) begin
			#4;
			rd_words[2 * k] = dq_hi_i;
			rd_words[2 * k + 1] = dq_lo_i;
			rd_oe_n[k] = dq_oe_n_i;
			@(posedge ck_i);
		end
	endtask
endmodule

/* testbench/ddr2_sdram_command_interface_tb.sv */
`timescale 1ns/100ps
// ==========================================
// Command interface testbench
module ddr2_sdram_command_interface_tb;
	import ddr2_cmd_pkg::*;

	logic mclk, ck, nrst, cke, cs_n, ras_n, cas_n, we_n, oe_n;
	logic drive_half, dll_locked, rx_cmd_en, rx_clk_en, pd, sref, odt, odt_en;
	logic [BANK_W-1:0] ba;
	logic [ADDR_W-1:0] a;
	logic [DQ_W-1:0] dqh_w, dql_w, dqh_r, dql_r;
	logic [DM_W-1:0] dmh, dml;
	logic [NBANK-1:0] banks;
	logic [DQ_W-1:0] exp_mem [16];
	int errors = 0;
	int check_count = 0;

	ddr2_sdram_command_interface i_ddr2_sdram_command_interface (
		.mclk_i(mclk), .nrst_i(nrst), .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n),
		.ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .odt_i(odt), .ba_i(ba),
		.a_i(a), .width_x8_i(1'b0), .dq_hi_i(dqh_w), .dq_lo_i(dql_w), .dm_hi_i(dmh),
		.dm_lo_i(dml), .dq_hi_o(dqh_r), .dq_lo_o(dql_r), .dq_oe_n_o(oe_n),
		.drive_half_o(drive_half), .dll_locked_o(dll_locked), .rx_cmd_en_o(rx_cmd_en),
		.rx_clk_en_o(rx_clk_en), .odt_en_o(odt_en), .pd_o(pd), .sref_o(sref),
		.banks_open_o(banks));
	ddr2_host i_ddr2_host (
		.ck_i(ck), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
		.we_n_o(we_n), .ba_o(ba), .a_o(a), .dq_hi_o(dqh_w), .dq_lo_o(dql_w), .dm_hi_o(dmh),
		.dm_lo_o(dml), .dq_hi_i(dqh_r), .dq_lo_i(dql_r), .dq_oe_n_i(oe_n));

	// Clocks, unrelated in phase
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		ck = 1'b0;
		#7;
		forever #32 ck = ~ck;
	end

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask

	// Column of burst word i, sequential wrap or interleaved
	function automatic int col_at(input int s, input int i, input int bl, input logic intlv);
		if (intlv) begin
			return s ^ i;
		end
		return (s & ~(bl - 1)) | ((s + i) & (bl - 1));
	endfunction

	// Burst from column 0; fully masked high words leave old data
	task automatic wr(input logic [BANK_W-1:0] bank, input int wl, input int bl,
		input logic [3:0] tag, input logic [DM_W-1:0] dmh_v);
		i_ddr2_host.wr_burst(bank, wl, bl / 2, tag, dmh_v);
		for (int i = 0; i < bl; i++) begin
			if (i % 2 == 1 || dmh_v != 2'h3) begin
				exp_mem[i] = {tag, 12'(i)};
			end
		end
	endtask

	task automatic rd_check(input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] addr,
		input int rl, input int bl, input logic intlv);
		i_ddr2_host.rd_burst(CMD_RD, bank, addr, rl, bl / 2);
		for (int i = 0; i < bl; i++) begin
			chk(i_ddr2_host.rd_words[i], exp_mem[col_at(addr[3:0], i, bl, intlv)]);
		end
		for (int k = 0; k < bl / 2; k++) begin
			chk_bit(i_ddr2_host.rd_oe_n[k], 1'b0);
		end
	endtask

	task automatic wait_status();
		repeat (6) @(posedge ck);
		#4;
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		odt = 1'b0;
		repeat (4) @(posedge ck);
		#2;
		nrst = 1'b1;
		repeat (4) @(posedge ck);
		#4;
		chk_bit(oe_n, 1'b1);
		chk_bit(rx_cmd_en, 1'b1);
		chk({8'h00, banks}, 16'h0000);
		repeat (200) @(posedge ck);
		#4;
		chk_bit(dll_locked, 1'b1);
		chk_bit(drive_half, 1'b0);
		$display("Test reset and lock finished");
		i_ddr2_host.send(CMD_ACT, 3'h2, 15'h1234, 1'b1);
		i_ddr2_host.send(CMD_ACT, 3'h5, 15'h4321, 1'b1);
		wait_status();
		chk({8'h00, banks}, 16'h0024);
		wr(3'h2, 2, 4, 4'h1, 2'h0);
		wr(3'h2, 2, 4, 4'h2, 2'h3);
		rd_check(3'h2, 15'h0001, 3, 4, 1'b0);
		i_ddr2_host.rd_burst(4'hD, 3'h2, 15'h0001, 3, 2);
		chk_bit(i_ddr2_host.rd_oe_n[0], 1'b1);
		chk_bit(i_ddr2_host.rd_oe_n[1], 1'b1);
		$display("Test burst data finished");
		for (int bt = 0; bt < 2; bt++) begin
			i_ddr2_host.mode_set(15'h0043 | 15'(bt << 3), 15'h0012);
			i_ddr2_host.send(CMD_ACT, 3'h5, 15'h0077, 1'b1);
			wr(3'h5, 5, 8, 4'h3, 2'h0);
			rd_check(3'h5, 15'h0002 | 15'(bt << 10), 6, 8, bt[0]);
		end
		wait_status();
		chk({8'h00, banks}, 16'h0000);
		chk_bit(drive_half, 1'b1);
		$display("Test modes finished");
		i_ddr2_host.send(CMD_ACT, 3'h2, 15'h0100, 1'b1);
		i_ddr2_host.send(CMD_ACT, 3'h6, 15'h0200, 1'b1);
		i_ddr2_host.send(CMD_PRE, 3'h6, 15'h0000, 1'b1);
		wait_status();
		chk({8'h00, banks}, 16'h0004);
		chk_bit(odt_en, 1'b0);
		@(posedge ck);
		#2;
		odt = 1'b1;
		i_ddr2_host.set_cke(1'b0);
		wait_status();
		chk_bit(pd, 1'b1);
		chk_bit(rx_cmd_en, 1'b0);
		chk_bit(rx_clk_en, 1'b1);
		chk_bit(odt_en, 1'b1);
		i_ddr2_host.set_cke(1'b1);
		wait_status();
		chk_bit(pd, 1'b0);
		chk({8'h00, banks}, 16'h0004);
		$display("Test power-down finished");
		i_ddr2_host.send(CMD_PRE, 3'h0, 15'h0400, 1'b1);
		i_ddr2_host.send(CMD_REF, 3'h0, 15'h0000, 1'b0);
		wait_status();
		chk_bit(sref, 1'b1);
		chk_bit(rx_clk_en, 1'b0);
		chk_bit(odt_en, 1'b0);
		chk_bit(dll_locked, 1'b0);
		i_ddr2_host.set_cke(1'b1);
		wait_status();
		chk_bit(sref, 1'b0);
		chk_bit(rx_cmd_en, 1'b1);
		$display("Test self refresh finished");
		close_out();
	end

	// Watchdog well past the expected run
	initial begin
		#100000;
		errors++;
		close_out();
	end
endmodule
